/* File: cam_core.sv */
`default_nettype none
// Summary of operation
// RULE1: Ten addressing modes form the effective address.
// RULE2: Immediate operand is the byte after opcode.
// RULE3: Direct: one address byte, low 256, two bytes.
// RULE4: Extended: two address bytes, three-byte instruction.
// RULE5: Branch adds signed offset only when taken.
// RULE6: Offset span -128..+127 from next opcode.
// RULE7: Indexed no offset: index is address, one byte.
// RULE8: Index plus unsigned byte, up to 510.
// RULE9: Index plus unsigned 16-bit field, three bytes.
// RULE10: Bit set/clear: bit in opcode, direct address.
// RULE11: Bit test: bit, polarity, address, signed offset.
// RULE12: Tested bit is copied into carry.
// RULE13: Inherent instructions are one byte long.
// RULE14: Decode the register-reference control operations.
// RULE15: Program counter is 13 bits, next byte.
// RULE16: Two-byte fields high byte first; short upper zero.
// RULE17: Wide addresses truncated to program address width.
module cam_core #(
  parameter int              PC_W   = cam_pkg::CAM_PC_W,
  parameter logic [PC_W-1:0] RST_PC = cam_pkg::CAM_PC_RST
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_nrst,
  // Core side
  input  wire logic              i_run,
  input  wire logic [7:0]        i_index,
  input  wire logic              i_branch_cond,
  // Memory bus
  output logic                   o_mem_rd,
  output logic [PC_W-1:0]        o_mem_addr,
  input  wire logic              i_mem_valid,
  input  wire logic [7:0]        i_mem_data,
  // Decode results
  output logic                   o_done,
  output cam_pkg::cam_mode_t     o_mode,
  output logic [1:0]             o_len,
  output logic [7:0]             o_opcode,
  output logic [7:0]             o_operand,
  output logic [PC_W-1:0]        o_eff_addr,
  output logic [2:0]             o_bit_num,
  output logic                   o_taken,
  output cam_pkg::cam_ctl_t      o_ctl,
  output logic                   o_carry_wr,
  output logic                   o_carry_val,
  output logic [PC_W-1:0]        o_pc
);
  import cam_pkg::*;

  if (PC_W < 9 || PC_W > 16) begin : g_chk
    $error("PC_W must lie between 9 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  cam_state_t      state_ff, nxt_state;
  logic [1:0]      ph_ff, nxt_ph;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic [7:0]      opc_ff, nxt_opc;
  logic [7:0]      b1_ff, nxt_b1;
  logic [7:0]      b2_ff, nxt_b2;
  logic [7:0]      dat_ff, nxt_dat;
  logic            rd_ff, nxt_rd;
  logic [PC_W-1:0] addr_ff, nxt_addr;
  logic            done_ff;
  cam_mode_t       mode_ff;
  logic [1:0]      len_ff;
  logic [PC_W-1:0] eff_addr_ff, nxt_eff_addr;
  logic            taken_ff;
  cam_ctl_t        ctl_ff;
  logic            cwr_ff;
  logic            cval_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode tables
  function automatic cam_mode_t mode_of(input logic [7:0] op);
    case (op[7:4])
      4'h0:    mode_of = CAM_M_BTB;
      4'h1:    mode_of = CAM_M_BSC;
      4'h2:    mode_of = CAM_M_REL;
      4'h3:    mode_of = CAM_M_DIR;
      4'h6:    mode_of = CAM_M_IX1;
      4'h7:    mode_of = CAM_M_IX;
      4'hA:    mode_of = (op == CAM_OP_BSR) ? CAM_M_REL : CAM_M_IMM;
      4'hB:    mode_of = CAM_M_DIR;
      4'hC:    mode_of = CAM_M_EXT;
      4'hD:    mode_of = CAM_M_IX2;
      4'hE:    mode_of = CAM_M_IX1;
      4'hF:    mode_of = CAM_M_IX;
      default: mode_of = CAM_M_INH; // 4x, 5x, 8x, 9x
    endcase
  endfunction : mode_of

  // Byte count follows the mode alone
  function automatic logic [1:0] len_of(input cam_mode_t m);
    case (m)
      CAM_M_EXT, CAM_M_IX2, CAM_M_BTB: len_of = CAM_LEN3; // RULE4 RULE9 RULE11
      CAM_M_IX, CAM_M_INH:             len_of = CAM_LEN1; // RULE7 RULE13
      default:                         len_of = CAM_LEN2; // RULE2 RULE3 RULE8 RULE10
    endcase
  endfunction : len_of

  function automatic cam_ctl_t ctl_of(input logic [7:0] op);
    case (op)
      CAM_OP_A2X:  ctl_of = CAM_C_COPY_ACC_TO_INDEX;
      CAM_OP_X2A:  ctl_of = CAM_C_COPY_INDEX_TO_ACC;
      CAM_OP_CY1:  ctl_of = CAM_C_SET_CARRY;
      CAM_OP_CY0:  ctl_of = CAM_C_CLEAR_CARRY;
      CAM_OP_IM1:  ctl_of = CAM_C_MASK_INT;
      CAM_OP_IM0:  ctl_of = CAM_C_UNMASK_INT;
      CAM_OP_TRAP: ctl_of = CAM_C_SW_TRAP;
      CAM_OP_SRET: ctl_of = CAM_C_SUB_RETURN;
      CAM_OP_IRET: ctl_of = CAM_C_INT_RETURN;
      CAM_OP_SPI:  ctl_of = CAM_C_SP_REINIT;
      CAM_OP_IDLE: ctl_of = CAM_C_IDLE;
      CAM_OP_STOP: ctl_of = CAM_C_STOP;
      CAM_OP_WAIT: ctl_of = CAM_C_WAIT;
      default:     ctl_of = CAM_C_NONE;
    endcase
  endfunction : ctl_of

  ////////////////////////////////////////////////////////////////////////////
  // Decode wires; the opcode is decoded as it arrives
  wire             op_arrive = (state_ff == CAM_ST_WAIT) &&
                               (ph_ff == CAM_PH_OPC);
  wire [7:0]       dec_op    = op_arrive ? i_mem_data : opc_ff;
  cam_mode_t       mode_w;
  assign mode_w = mode_of(dec_op); // RULE1
  wire [1:0]       len_w     = len_of(mode_w);
  wire [1:0]       ph_inc    = ph_ff + 2'h1;
  wire             more_ins  = (ph_ff != CAM_PH_DAT) && (ph_inc < len_w);
  wire             need_dat  = (mode_w == CAM_M_BTB) &&
                               (ph_ff == CAM_PH_B2);
  wire [PC_W-1:0]  pc_inc    = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};

  // Short addresses sit in page zero
  wire [PC_W-1:0]  dir_addr  = {{(PC_W-8){1'b0}}, b1_ff}; // RULE16
  wire [PC_W-1:0]  ix_addr   = {{(PC_W-8){1'b0}}, i_index};
  wire [8:0]       ix1_sum   = {1'b0, b1_ff} + {1'b0, i_index}; // RULE8
  wire [15:0]      wide      = {b1_ff, b2_ff}; // RULE16
  wire [16:0]      ix2_sum   = {1'b0, wide} + {9'h000, i_index}; // RULE9

  // Offset is the last byte; target is relative to the next opcode
  wire [7:0]       off       = (mode_w == CAM_M_BTB) ? b2_ff : b1_ff;
  wire [PC_W-1:0]  off_sx    = {{(PC_W-8){off[7]}}, off}; // RULE6
  wire [PC_W-1:0]  target    = pc_ff + off_sx;

  // Bit test: even opcode branches on set, odd on clear
  wire             tested    = dat_ff[opc_ff[3:1]]; // RULE11
  wire             btb_take  = tested ^ opc_ff[0];
  wire             take_w    = (mode_w == CAM_M_REL) ? i_branch_cond :
                               (mode_w == CAM_M_BTB) ? btb_take : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Effective address per mode
  always_comb begin
    case (mode_w)
      CAM_M_DIR, CAM_M_BSC, CAM_M_BTB: nxt_eff_addr = dir_addr; // RULE3 RULE10
      CAM_M_EXT: nxt_eff_addr = wide[PC_W-1:0]; // RULE4 RULE17
      CAM_M_IX:  nxt_eff_addr = ix_addr; // RULE7
      CAM_M_IX1: nxt_eff_addr = {{(PC_W-9){1'b0}}, ix1_sum};
      CAM_M_IX2: nxt_eff_addr = ix2_sum[PC_W-1:0]; // RULE17
      CAM_M_REL: nxt_eff_addr = target;
      default:   nxt_eff_addr = {PC_W{1'b0}}; // RULE2
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: one read in flight, no prefetch, so a stalled bus
  // simply holds the sequencer in the wait state
  always_comb begin
    nxt_state = state_ff;
    nxt_ph    = ph_ff;
    nxt_pc    = pc_ff;
    nxt_opc   = opc_ff;
    nxt_b1    = b1_ff;
    nxt_b2    = b2_ff;
    nxt_dat   = dat_ff;
    nxt_rd    = 1'b0;
    nxt_addr  = addr_ff;
    case (state_ff)
      CAM_ST_IDLE: begin
        if (i_run) begin
          nxt_rd    = 1'b1;
          nxt_addr  = pc_ff;
          nxt_ph    = CAM_PH_OPC;
          nxt_state = CAM_ST_WAIT;
        end
      end
      CAM_ST_WAIT: begin
        if (i_mem_valid) begin
          case (ph_ff)
            2'h0:    nxt_opc = i_mem_data;
            2'h1:    nxt_b1  = i_mem_data;
            2'h2:    nxt_b2  = i_mem_data;
            default: nxt_dat = i_mem_data;
          endcase
          // PC tracks the next instruction byte
          if (ph_ff != CAM_PH_DAT) begin
            nxt_pc = pc_inc; // RULE15
          end
          if (more_ins) begin
            nxt_rd   = 1'b1;
            nxt_addr = pc_inc;
            nxt_ph   = ph_inc;
          end else if (need_dat) begin
            nxt_rd   = 1'b1;
            nxt_addr = dir_addr; // RULE11
            nxt_ph   = CAM_PH_DAT;
          end else begin
            nxt_state = CAM_ST_EXEC;
          end
        end
      end
      CAM_ST_EXEC: begin
        if (take_w) begin
          nxt_pc = target; // RULE5
        end
        nxt_state = CAM_ST_IDLE;
      end
      default: nxt_state = CAM_ST_IDLE;
    endcase
  end

  wire exec = (state_ff == CAM_ST_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= CAM_ST_IDLE;
      ph_ff    <= CAM_PH_OPC;
      pc_ff    <= RST_PC;
      opc_ff   <= 8'h00;
      b1_ff    <= 8'h00;
      b2_ff    <= 8'h00;
      dat_ff   <= 8'h00;
      rd_ff    <= 1'b0;
      addr_ff  <= {PC_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      ph_ff    <= nxt_ph;
      pc_ff    <= nxt_pc;
      opc_ff   <= nxt_opc;
      b1_ff    <= nxt_b1;
      b2_ff    <= nxt_b2;
      dat_ff   <= nxt_dat;
      rd_ff    <= nxt_rd;
      addr_ff  <= nxt_addr;
    end
  end

  // Results; done and carry write pulse for one cycle, the rest held until the next instruction completes
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      done_ff  <= 1'b0;
      mode_ff  <= CAM_M_INH;
      len_ff   <= CAM_LEN1;
      eff_addr_ff <= {PC_W{1'b0}};
      taken_ff <= 1'b0;
      ctl_ff   <= CAM_C_NONE;
      cwr_ff   <= 1'b0;
      cval_ff  <= 1'b0;
    end else begin
      done_ff <= exec;
      cwr_ff  <= exec && (mode_w == CAM_M_BTB); // RULE12
      if (exec) begin
        mode_ff  <= mode_w;
        len_ff   <= len_w;
        eff_addr_ff <= nxt_eff_addr;
        taken_ff <= take_w;
        ctl_ff   <= ctl_of(opc_ff); // RULE14
        cval_ff  <= tested; // RULE12
      end
    end
  end

  assign o_mem_rd    = rd_ff;
  assign o_mem_addr  = addr_ff;
  assign o_done      = done_ff;
  assign o_mode      = mode_ff;
  assign o_len       = len_ff;
  assign o_opcode    = opc_ff;
  assign o_operand   = b1_ff;
  assign o_eff_addr  = eff_addr_ff;
  assign o_bit_num   = opc_ff[3:1];
  assign o_taken     = taken_ff;
  assign o_ctl       = ctl_ff;
  assign o_carry_wr  = cwr_ff;
  assign o_carry_val = cval_ff;
  assign o_pc        = pc_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks; reads since the last completion
  logic [2:0] rdn_ff;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rdn_ff <= 3'h0;
    end else if (done_ff) begin
      rdn_ff <= {2'h0, rd_ff};
    end else if (rd_ff) begin
      rdn_ff <= rdn_ff + 3'h1;
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  sequence s_fin(cam_mode_t m);
    done_ff && mode_ff == m;
  endsequence

  a_imm_no_access: assert property (s_fin(CAM_M_IMM) |-> rdn_ff == 3'h2) // RULE2
    else $error("immediate made an extra access");
  a_dir_page_zero: assert property (s_fin(CAM_M_DIR) |->
    eff_addr_ff[PC_W-1:8] == '0 && len_ff == CAM_LEN2) // RULE3
    else $error("direct address outside page zero");
  a_ext_len_three: assert property (s_fin(CAM_M_EXT) |->
    len_ff == CAM_LEN3 && rdn_ff == 3'h3) // RULE4
    else $error("extended length wrong");
  a_rel_not_taken: assert property (exec && mode_w == CAM_M_REL &&
    !i_branch_cond |=> pc_ff == $past(pc_ff) && !taken_ff) // RULE5
    else $error("untaken branch moved the pc");
  a_rel_target: assert property (exec && take_w |=>
    pc_ff == $past(target) ##1 o_pc == $past(pc_ff)) // RULE6
    else $error("branch target wrong");
  a_ix1_range: assert property (s_fin(CAM_M_IX1) |->
    eff_addr_ff <= 510) // RULE8
    else $error("short indexed address beyond 510");
  a_inh_one_byte: assert property (s_fin(CAM_M_INH) |->
    rdn_ff == 3'h1) // RULE13
    else $error("inherent fetched more than one byte");
  a_btb_carry: assert property (exec && mode_w == CAM_M_BTB |=>
    cwr_ff && cval_ff == $past(tested) ##1 !cwr_ff) // RULE12
    else $error("carry not loaded from tested bit");
  a_rd_pulse: assert property (rd_ff |=> !rd_ff) // RULE15
    else $error("read strobe longer than one cycle");
endmodule : cam_core
`default_nettype wire

/* File: cam_mem_model.sv */
`default_nettype none
// Program and data memory answering fetch strobes after a set delay
module cam_mem_model (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Fetch bus
  input  wire logic        i_rd,
  input  wire logic [12:0] i_addr,
  input  wire logic [3:0]  i_lat,
  output logic             o_valid,
  output logic [7:0]       o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  mem [0:8191];
  logic [12:0] addr_ff;
  logic [3:0]  cnt_ff;
  logic        pend_ff;

  ////////////////////////////////////////////////////////////////////////
  // One answer per strobe; idle data toggles so a stale byte never matches
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_data  <= 8'h00;
      pend_ff <= 1'b0;
      cnt_ff  <= 4'h0;
      addr_ff <= 13'h0000;
    end else begin
      o_valid <= 1'b0;
      o_data  <= ~o_data;
      if (pend_ff) begin
        if (cnt_ff == 4'h0) begin
          o_valid <= 1'b1;
          o_data  <= mem[addr_ff];
          pend_ff <= 1'b0;
        end else begin
          cnt_ff <= cnt_ff - 4'h1;
        end
      end
      if (i_rd) begin
        addr_ff <= i_addr;
        if (i_lat == 4'h0) begin
          o_valid <= 1'b1;
          o_data  <= mem[i_addr];
        end else begin
          pend_ff <= 1'b1;
          cnt_ff  <= i_lat - 4'h1;
        end
      end
    end
  end
endmodule : cam_mem_model
`default_nettype wire

/* File: cam_pkg.sv */
`default_nettype none
package cam_pkg;
  // Address space and reset
  localparam int          CAM_PC_W   = 13;
  localparam logic [12:0] CAM_PC_RST = 13'h0000;
  // Instruction lengths in bytes
  localparam logic [1:0]  CAM_LEN1   = 2'h1;
  localparam logic [1:0]  CAM_LEN2   = 2'h2;
  localparam logic [1:0]  CAM_LEN3   = 2'h3;
  // Fetch phases: opcode, two operand bytes, tested data byte
  localparam logic [1:0]  CAM_PH_OPC = 2'h0;
  localparam logic [1:0]  CAM_PH_B2  = 2'h2;
  localparam logic [1:0]  CAM_PH_DAT = 2'h3;
  // Opcodes that need more than the class nibble
  localparam logic [7:0]  CAM_OP_BSR  = 8'hAD;
  localparam logic [7:0]  CAM_OP_A2X  = 8'h97;
  localparam logic [7:0]  CAM_OP_X2A  = 8'h9F;
  localparam logic [7:0]  CAM_OP_CY1  = 8'h99;
  localparam logic [7:0]  CAM_OP_CY0  = 8'h98;
  localparam logic [7:0]  CAM_OP_IM1  = 8'h9B;
  localparam logic [7:0]  CAM_OP_IM0  = 8'h9A;
  localparam logic [7:0]  CAM_OP_TRAP = 8'h83;
  localparam logic [7:0]  CAM_OP_SRET = 8'h81;
  localparam logic [7:0]  CAM_OP_IRET = 8'h80;
  localparam logic [7:0]  CAM_OP_SPI  = 8'h9C;
  localparam logic [7:0]  CAM_OP_IDLE = 8'h9D;
  localparam logic [7:0]  CAM_OP_STOP = 8'h8E;
  localparam logic [7:0]  CAM_OP_WAIT = 8'h8F;

  typedef enum logic [3:0] {
    CAM_M_IMM = 4'h0, CAM_M_DIR = 4'h1, CAM_M_EXT = 4'h2,
    CAM_M_REL = 4'h3, CAM_M_IX  = 4'h4, CAM_M_IX1 = 4'h5,
    CAM_M_IX2 = 4'h6, CAM_M_BSC = 4'h7, CAM_M_BTB = 4'h8,
    CAM_M_INH = 4'h9
  } cam_mode_t;

  typedef enum logic [3:0] {
    CAM_C_NONE = 4'h0, CAM_C_COPY_ACC_TO_INDEX = 4'h1,
    CAM_C_COPY_INDEX_TO_ACC = 4'h2, CAM_C_SET_CARRY = 4'h3,
    CAM_C_CLEAR_CARRY = 4'h4, CAM_C_MASK_INT = 4'h5,
    CAM_C_UNMASK_INT = 4'h6, CAM_C_SW_TRAP = 4'h7,
    CAM_C_SUB_RETURN = 4'h8, CAM_C_INT_RETURN = 4'h9,
    CAM_C_SP_REINIT = 4'hA, CAM_C_IDLE = 4'hB,
    CAM_C_STOP = 4'hC, CAM_C_WAIT = 4'hD
  } cam_ctl_t;

  typedef enum logic [1:0] {
    CAM_ST_IDLE = 2'h0, CAM_ST_WAIT = 2'h1, CAM_ST_EXEC = 2'h2
  } cam_state_t;
endpackage : cam_pkg
`default_nettype wire

/* File: tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cam_pkg::*;

  logic        i_clock, i_nrst, i_run, i_branch_cond;
  logic [7:0]  i_index, i_mem_data, o_opcode, o_operand;
  logic        o_mem_rd, i_mem_valid, o_done, o_taken;
  logic        o_carry_wr, o_carry_val;
  logic [12:0] o_mem_addr, o_eff_addr, o_pc, pc;
  logic [1:0]  o_len;
  logic [2:0]  o_bit_num;
  logic [3:0]  lat;
  cam_mode_t   o_mode;
  cam_ctl_t    o_ctl;
  int          errors, comparisons;

  cam_core u_cam_core (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_run(i_run), .i_index(i_index), .i_branch_cond(i_branch_cond),
    .o_mem_rd(o_mem_rd), .o_mem_addr(o_mem_addr),
    .i_mem_valid(i_mem_valid), .i_mem_data(i_mem_data),
    .o_done(o_done), .o_mode(o_mode), .o_len(o_len),
    .o_opcode(o_opcode), .o_operand(o_operand), .o_eff_addr(o_eff_addr),
    .o_bit_num(o_bit_num), .o_taken(o_taken), .o_ctl(o_ctl),
    .o_carry_wr(o_carry_wr), .o_carry_val(o_carry_val), .o_pc(o_pc));

  cam_mem_model u_cam_mem_model (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_rd(o_mem_rd), .i_addr(o_mem_addr), .i_lat(lat),
    .o_valid(i_mem_valid), .o_data(i_mem_data));

  ////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns
  always #2 i_clock = ~i_clock;

  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Inputs move 1 ns after the edge so no race with the design
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask : tick

  // Load one instruction at pc, start it, wait for done, check common fields
  task automatic exec(input logic [7:0] b0, b1, b2, input logic [1:0] ln,
                      input cam_mode_t md, input logic [12:0] adr, npc);
    int n;
    u_cam_mem_model.mem[pc] = b0;
    u_cam_mem_model.mem[pc + 13'h0001] = b1;
    u_cam_mem_model.mem[pc + 13'h0002] = b2;
    tick();
    i_run = 1'b1;
    tick();
    i_run = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    if (o_done !== 1'b1) begin
      errors++;
      give_verdict();
    end else begin
      chk("opcode", b0, o_opcode);
      chk("length", ln, o_len);
      chk("mode", md, o_mode);
      chk("eff addr", adr, o_eff_addr);
      chk("pc", npc, o_pc);
      pc = npc;
      lat = lat ^ 4'h3; // Alternate prompt and slow memory
    end
  endtask : exec

  task automatic t_reset;
    chk("reset mode", CAM_M_INH, o_mode);
    chk("reset pc", 16'h0000, o_pc);
    chk("reset rd", 16'h0000, o_mem_rd);
  endtask : t_reset

  task automatic t_imm_dir_ext;
    exec(8'hA6, 8'h5A, 8'h00, 2'h2, CAM_M_IMM, 13'h0000, pc + 13'h0002);
    chk("operand", 16'h005A, o_operand);
    exec(8'hB6, 8'h80, 8'h00, 2'h2, CAM_M_DIR, 13'h0080, pc + 13'h0002);
    exec(8'hC6, 8'hF2, 8'h34, 2'h3, CAM_M_EXT, 13'h1234, pc + 13'h0003);
  endtask : t_imm_dir_ext

  task automatic t_indexed;
    i_index = 8'hFF;
    exec(8'hF6, 8'h00, 8'h00, 2'h1, CAM_M_IX, 13'h00FF, pc + 13'h0001);
    exec(8'hE6, 8'hFF, 8'h00, 2'h2, CAM_M_IX1, 13'h01FE, pc + 13'h0002);
    i_index = 8'h10;
    exec(8'hD6, 8'hFF, 8'hFF, 2'h3, CAM_M_IX2, 13'h000F, pc + 13'h0003);
  endtask : t_indexed

  // Bit test data sits at 0xF0, clear of the program area
  task automatic t_bits;
    exec(8'h1B, 8'hF0, 8'h00, 2'h2, CAM_M_BSC, 13'h00F0, pc + 13'h0002);
    chk("bit num", 16'h0005, o_bit_num);
    u_cam_mem_model.mem[8'hF0] = 8'h08;
    exec(8'h06, 8'hF0, 8'h10, 2'h3, CAM_M_BTB, 13'h00F0, pc + 13'h0013);
    chk("data addr", 16'h00F0, u_cam_mem_model.addr_ff);
    chk("bit num", 16'h0003, o_bit_num);
    chk("carry wr", 16'h0001, o_carry_wr);
    chk("carry val", 16'h0001, o_carry_val);
    exec(8'h07, 8'hF0, 8'h10, 2'h3, CAM_M_BTB, 13'h00F0, pc + 13'h0003);
    chk("taken", 16'h0000, o_taken);
    u_cam_mem_model.mem[8'hF0] = 8'hF7;
    exec(8'h07, 8'hF0, 8'hF0, 2'h3, CAM_M_BTB, 13'h00F0, pc - 13'h000D);
    chk("carry val", 16'h0000, o_carry_val);
    chk("taken", 16'h0001, o_taken);
  endtask : t_bits

  task automatic t_relative;
    logic [12:0] t;
    i_branch_cond = 1'b1;
    t = pc + 13'h0002 - 13'h0080;
    exec(8'h20, 8'h80, 8'h00, 2'h2, CAM_M_REL, t, t);
    chk("taken", 16'h0001, o_taken);
    t = pc + 13'h0002 + 13'h007F;
    exec(8'h20, 8'h7F, 8'h00, 2'h2, CAM_M_REL, t, t);
    // Subroutine call shares the relative decode of the branches
    exec(CAM_OP_BSR, 8'h02, 8'h00, 2'h2, CAM_M_REL, pc + 13'h0004,
         pc + 13'h0004);
    i_branch_cond = 1'b0;
    t = pc + 13'h0007;
    exec(8'h20, 8'h05, 8'h00, 2'h2, CAM_M_REL, t, pc + 13'h0002);
    chk("taken", 16'h0000, o_taken);
  endtask : t_relative

  // Index in the table equals the expected control code
  task automatic t_inherent;
    logic [7:0] ops [14];
    ops = '{8'h4C, CAM_OP_A2X, CAM_OP_X2A, CAM_OP_CY1, CAM_OP_CY0,
            CAM_OP_IM1, CAM_OP_IM0, CAM_OP_TRAP, CAM_OP_SRET, CAM_OP_IRET,
            CAM_OP_SPI, CAM_OP_IDLE, CAM_OP_STOP, CAM_OP_WAIT};
    for (int i = 0; i < 14; i++) begin
      exec(ops[i], 8'h00, 8'h00, 2'h1, CAM_M_INH, 13'h0000,
           pc + 13'h0001);
      chk("ctl", 16'(i), o_ctl);
    end
  endtask : t_inherent

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_clock = 1'b0;
    i_nrst = 1'b0;
    i_run = 1'b0;
    i_index = 8'h00;
    i_branch_cond = 1'b0;
    lat = 4'h0;
    pc = 13'h0000;
    errors = 0;
    comparisons = 0;
    repeat (12) tick();
    t_reset();
    i_nrst = 1'b1;
    t_imm_dir_ext();
    t_indexed();
    t_bits();
    t_relative();
    t_inherent();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
